// *** hdl/ssaf_pkg.sv ***
// ssaf_pkg: constants for the station address filter of the two sdlc ports
// assumes a single 40 MHz clock domain and byte-wide frame streams
package ssaf_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned MIN_LINK_BPS    = 1000000;
  // cycles per link bit at the least sustained rate, rounded down
  localparam int unsigned BIT_CYCLES      = CLK_HZ / MIN_LINK_BPS;
  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned FIFO_DEPTH      = 32;
  // field io port addresses
  localparam logic [7:0]  FIO_CPU_ADDR    = 8'h13;
  localparam logic [7:0]  FIO_MOD_ADDR    = 8'h14;
  localparam logic [7:0]  FIO_BCAST_ADDR  = 8'h7f;
  // auxiliary port addresses
  localparam logic [7:0]  AUX_CPU_ADDR    = 8'h13;
  localparam logic [7:0]  AUX_BCAST_ADDR  = 8'hff;
  typedef enum logic {SSAF_CPU, SSAF_FIELD_IO} ssaf_role_e;
  typedef enum logic {SSAF_PORT_FIO, SSAF_PORT_AUX} ssaf_port_e;
endpackage : ssaf_pkg

// *** hdl/ssaf_fifo.sv ***
// ssaf_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ssaf_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  // honest full and empty from the fill count
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  assign outData  = mem[rdPtr];

  // storage write
  always_ff @(posedge clk)
  begin
    if (doWr)
      mem[wrPtr] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWr)
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (doRd)
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      if (doWr && !doRd)
        count <= count + 1'b1;
      else if (doRd && !doWr)
        count <= count - 1'b1;
    end
  end
endmodule : ssaf_fifo
`default_nettype wire

// *** hdl/ssaf_filter.sv ***
// ssaf_filter: station address filter and response addressing for one sdlc port
// assumes framing (flags, stuffing, crc) is done outside; frames arrive as bytes
// with a first/last marker, from the line receiver on the same clock
`timescale 1ns/1ps
`default_nettype none
module ssaf_filter
  import ssaf_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire ssaf_pkg::ssaf_role_e    stationRole,
  input  wire ssaf_pkg::ssaf_port_e    portSel,
  input  wire logic                    rxDataPos,
  input  wire logic                    rxDataNeg,
  input  wire logic                    requestPos,
  input  wire logic                    requestNeg,
  output logic                         rxBit,
  output logic                         requestActive,
  input  wire logic [7:0]              rxByte,
  input  wire logic                    rxFirst,
  input  wire logic                    rxLast,
  input  wire logic                    rxValid,
  output logic                         rxReady,
  output logic [7:0]                   cmdByte,
  output logic                         cmdFirst,
  output logic                         cmdLast,
  output logic                         cmdValid,
  input  wire logic                    cmdReady,
  output logic [7:0]                   cmdAddr,
  output logic                         cmdBroadcast,
  output logic                         frameDropped,
  input  wire logic                    respStart,
  output logic [7:0]                   respAddr,
  output logic                         respAddrValid,
  output logic                         stationEnabled,
  output logic                         txPos,
  output logic                         txNeg,
  input  wire logic                    txBit
);
  import ssaf_pkg::*;

  typedef enum logic [1:0] {ST_ADDR, ST_PASS, ST_DROP} ssaf_state_e;

  ssaf_state_e state;
  logic [2:0]  dataSync;
  logic [2:0]  reqSync;
  logic        rawData;
  logic        rawReq;
  logic [7:0]  ownAddr;
  logic [7:0]  bcastAddr;
  logic        hasAddr;
  logic        addrHit;
  logic        isBcast;
  logic        fifoInValid;
  logic        fifoInReady;
  logic [9:0]  fifoOut;
  logic        passByte;

  // line decode: differential compare, then three-stage sampling
  assign rawData = rxDataPos && !rxDataNeg;
  assign rawReq  = !requestPos && requestNeg;

  // pin synchronisers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dataSync <= 3'h0;
      reqSync  <= 3'h0;
    end
    else
    begin
      dataSync <= {dataSync[1:0], rawData};
      reqSync  <= {reqSync[1:0], rawReq};
    end
  end

  // decoded levels change only once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxBit         <= 1'b0;
      requestActive <= 1'b0;
    end
    else
    begin
      if (dataSync[2] == dataSync[1])
        rxBit <= dataSync[2];
      if (reqSync[2] == reqSync[1])
        requestActive <= reqSync[2];
    end
  end

  // transmit line: one drives positive high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txPos <= 1'b0;
      txNeg <= 1'b1;
    end
    else
    begin
      txPos <= txBit;
      txNeg <= !txBit;
    end
  end

  // own and broadcast address from port and role
  always_comb
  begin
    ownAddr   = FIO_CPU_ADDR;
    bcastAddr = FIO_BCAST_ADDR;
    hasAddr   = 1'b1;
    unique case (portSel)
      SSAF_PORT_FIO:
      begin
        ownAddr   = (stationRole == SSAF_CPU) ? FIO_CPU_ADDR : FIO_MOD_ADDR;
        bcastAddr = FIO_BCAST_ADDR;
      end
      SSAF_PORT_AUX:
      begin
        ownAddr   = AUX_CPU_ADDR;
        bcastAddr = AUX_BCAST_ADDR;
        hasAddr   = (stationRole == SSAF_CPU);
      end
    endcase
  end

  assign stationEnabled = hasAddr;
  // only assigned values match; all others are never adopted
  assign isBcast = hasAddr && (rxByte == bcastAddr);
  assign addrHit = hasAddr && ((rxByte == ownAddr) || isBcast);

  // pass accepted frames into the fifo; dropped frames drain at full rate
  assign passByte    = (state == ST_PASS) || (state == ST_ADDR && rxFirst && addrHit);
  assign fifoInValid = rxValid && passByte;
  assign rxReady     = passByte ? fifoInReady : 1'b1;

  // frame acceptance state
  always_ff @(posedge clk)
  begin
    if (rst)
      state <= ST_ADDR;
    else if (rxValid && rxReady)
    begin
      unique case (state)
        ST_ADDR:
          if (rxFirst && !rxLast)
            state <= addrHit ? ST_PASS : ST_DROP;
        ST_PASS, ST_DROP:
          if (rxLast)
            state <= ST_ADDR;
        default:
          state <= ST_ADDR;
      endcase
    end
  end

  // address of the last accepted command, and drop pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmdAddr      <= 8'h00;
      cmdBroadcast <= 1'b0;
      frameDropped <= 1'b0;
    end
    else
    begin
      frameDropped <= 1'b0;
      if (rxValid && rxReady && state == ST_ADDR && rxFirst)
      begin
        if (addrHit)
        begin
          cmdAddr      <= rxByte;
          cmdBroadcast <= isBcast;
        end
        else
          frameDropped <= 1'b1;
      end
    end
  end

  // response address echoes the command address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      respAddr      <= 8'h00;
      respAddrValid <= 1'b0;
    end
    else
    begin
      respAddrValid <= respStart;
      if (respStart)
        respAddr <= cmdAddr;
    end
  end

  ssaf_fifo #(
    .WIDTH (BYTE_W + 2),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rst      (rst),
    .inData   ({rxFirst, rxLast, rxByte}),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (cmdValid),
    .outReady (cmdReady)
  );

  assign cmdFirst = fifoOut[9];
  assign cmdLast  = fifoOut[8];
  assign cmdByte  = fifoOut[7:0];

  // assertions: address decode against the fixed tables, drop handling, response echo and receive line levels
  sequence s_addr_taken;
    rxValid && rxReady && state == ST_ADDR && rxFirst;
  endsequence
  // first byte taken and matched, or taken and foreign
  sequence s_cmd_hit;
    s_addr_taken ##0 addrHit;
  endsequence
  sequence s_cmd_miss;
    s_addr_taken ##0 !addrHit;
  endsequence

  AST_BCAST_VALUE: assert property (@(posedge clk) disable iff (rst)
    hasAddr |-> (bcastAddr == ((portSel == SSAF_PORT_FIO) ? 8'h7f : 8'hff)))
    else $error("broadcast address wrong for port");
  AST_OWN_FIO: assert property (@(posedge clk) disable iff (rst)
    (portSel == SSAF_PORT_FIO) |-> (ownAddr == ((stationRole == SSAF_CPU) ? 8'h13 : 8'h14)))
    else $error("own address wrong on field io port");
  AST_AUX_NOADDR: assert property (@(posedge clk) disable iff (rst)
    (portSel == SSAF_PORT_AUX && stationRole == SSAF_FIELD_IO) |-> !addrHit)
    else $error("field io module matched on auxiliary port");
  AST_ONLY_ASSIGNED: assert property (@(posedge clk) disable iff (rst)
    addrHit |-> (rxByte == 8'h13 || rxByte == 8'h14 || rxByte == 8'h7f || rxByte == 8'hff))
    else $error("unassigned address accepted");
  AST_DROP_PULSE: assert property (@(posedge clk) disable iff (rst)
    s_cmd_miss |=> frameDropped)
    else $error("foreign frame not reported as dropped");
  AST_DROP_NO_FIFO: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DROP) |-> !fifoInValid)
    else $error("dropped frame entered the fifo");
  AST_ECHO_ADDR: assert property (@(posedge clk) disable iff (rst)
    s_cmd_hit ##1 respStart
    |=> (respAddrValid && respAddr == $past(rxByte, 2)))
    else $error("response address differs from command address");
  AST_RX_LEVEL: assert property (@(posedge clk) disable iff (rst)
    (rxDataPos && !rxDataNeg) [*4] |=> rxBit)
    else $error("positive-high data not read as one");
  AST_REQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
    (!requestPos && requestNeg) [*4] |=> requestActive)
    else $error("positive-low handshake not read as asserted");
  AST_DRAIN: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DROP) |-> rxReady)
    else $error("dropped frame stalls the receive path");

  // assertions: command address capture and response echo
  AST_CMD_ADDR: assert property (@(posedge clk) disable iff (rst)
    s_cmd_hit |=> (cmdAddr == $past(rxByte)))
    else $error("accepted command address not kept");
  AST_BCAST_FLAG: assert property (@(posedge clk) disable iff (rst)
    s_cmd_hit |=> (cmdBroadcast == ($past(rxByte) == (($past(portSel) == SSAF_PORT_FIO) ? 8'h7f : 8'hff))))
    else $error("broadcast flag wrong for accepted command");
  AST_RESP_PULSE: assert property (@(posedge clk) disable iff (rst)
    respStart |=> respAddrValid)
    else $error("response address not presented after request");
  AST_RESP_HOLD: assert property (@(posedge clk) disable iff (rst)
    !respStart |=> $stable(respAddr))
    else $error("response address moved without a request");

  // assertions: frame path through the buffer
  AST_PASS_STORE: assert property (@(posedge clk) disable iff (rst)
    (state == ST_PASS && rxValid && rxReady) |-> fifoInValid)
    else $error("accepted frame byte not stored");
  AST_SINGLE_STAY: assert property (@(posedge clk) disable iff (rst)
    (s_addr_taken ##0 rxLast) |=> (state == ST_ADDR))
    else $error("single byte frame left the address state");

  // assertions: line levels, both ways
  AST_TX_PAIR: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (txPos == $past(txBit) && txNeg == !$past(txBit)))
    else $error("transmit pair does not follow the data bit");
  AST_RX_ZERO: assert property (@(posedge clk) disable iff (rst)
    (!(rxDataPos && !rxDataNeg)) [*4] |=> !rxBit)
    else $error("positive-low data not read as zero");
  AST_REQ_OFF: assert property (@(posedge clk) disable iff (rst)
    (!(!requestPos && requestNeg)) [*4] |=> !requestActive)
    else $error("positive-high handshake not read as inactive");
endmodule : ssaf_filter
`default_nettype wire

// *** test/ssaf_peer.sv ***
// ssaf_peer: far station model feeding received frame bytes
// assumes the filter's clock; the bench calls send and idle
`timescale 1ns/1ps
`default_nettype none
module ssaf_peer (
  input  wire logic       clk,
  output logic      [7:0] rxByte,
  output logic            rxFirst,
  output logic            rxLast,
  output logic            rxValid,
  input  wire logic       rxReady
);
  // quiet stream at time zero
  initial
  begin
    rxByte = 8'h00;
    rxFirst = 1'h0;
    rxLast = 1'h0;
    rxValid = 1'h0;
  end
  // offer one byte, held until taken
  task automatic send(input logic [7:0] b, input logic f, input logic l);
    logic ok;
    begin
      rxByte = b;
      rxFirst = f;
      rxLast = l;
      rxValid = 1'h1;
      do
      begin
        @(negedge clk);
        ok = rxReady;
        @(posedge clk);
      end while (ok !== 1'h1);
      #1;
    end
  endtask : send
  // release: lines flip so a stale byte never passes
  task automatic idle();
    begin
      rxValid = 1'h0;
      rxByte = ~rxByte;
      rxFirst = ~rxFirst;
      rxLast = ~rxLast;
    end
  endtask : idle
endmodule : ssaf_peer
`default_nettype wire

// *** test/ssaf_filter_bench.sv ***
// ssaf_filter_bench: self-checking bench for the station address filter
// assumes the peer model feeds frames; bench drives line pairs and handshakes
`timescale 1ns/1ps
`default_nettype none
module ssaf_filter_bench;
  import ssaf_pkg::*;
  typedef struct packed {logic role; logic port; logic [7:0] addr; logic acc; logic bc;} ssaf_row_s;
  logic       clk = 1'h0, rst = 1'h1, rxDataPos = 1'h0, rxDataNeg = 1'h1, requestPos = 1'h1;
  logic       requestNeg = 1'h0, cmdReady = 1'h1, respStart = 1'h0, txBit = 1'h0;
  ssaf_role_e stationRole = SSAF_CPU;
  ssaf_port_e portSel = SSAF_PORT_FIO;
  logic [7:0] rxByte, cmdByte, cmdAddr, respAddr, lastResp = 8'h00, expAddr = 8'h00;
  logic       rxFirst, rxLast, rxValid, rxReady, cmdFirst, cmdLast, cmdValid, cmdBroadcast;
  logic       frameDropped, respAddrValid, stationEnabled, txPos, txNeg, rxBit, requestActive;
  logic [9:0] gotQ [$];
  int         n_mismatch = 0, samples_checked = 0, nDrop = 0, nResp = 0, cycles = 0, nd, nq, nr;
  ssaf_row_s  r;
  // role, port, address byte, accepted, broadcast
  ssaf_row_s  rows [12] = '{
    '{1'h0, 1'h0, 8'h13, 1'h1, 1'h0}, '{1'h0, 1'h0, 8'h7f, 1'h1, 1'h1}, '{1'h0, 1'h0, 8'h14, 1'h0, 1'h0},
    '{1'h0, 1'h0, 8'h55, 1'h0, 1'h0}, '{1'h1, 1'h0, 8'h14, 1'h1, 1'h0}, '{1'h1, 1'h0, 8'h7f, 1'h1, 1'h1},
    '{1'h1, 1'h0, 8'h13, 1'h0, 1'h0}, '{1'h0, 1'h1, 8'h13, 1'h1, 1'h0}, '{1'h0, 1'h1, 8'hff, 1'h1, 1'h1},
    '{1'h0, 1'h1, 8'h7f, 1'h0, 1'h0}, '{1'h1, 1'h1, 8'h14, 1'h0, 1'h0}, '{1'h1, 1'h1, 8'hff, 1'h0, 1'h0}};

  ssaf_filter i_dut (
    .clk (clk), .rst (rst), .stationRole (stationRole), .portSel (portSel),
    .rxDataPos (rxDataPos), .rxDataNeg (rxDataNeg), .requestPos (requestPos), .requestNeg (requestNeg),
    .rxBit (rxBit), .requestActive (requestActive),
    .rxByte (rxByte), .rxFirst (rxFirst), .rxLast (rxLast), .rxValid (rxValid), .rxReady (rxReady),
    .cmdByte (cmdByte), .cmdFirst (cmdFirst), .cmdLast (cmdLast), .cmdValid (cmdValid), .cmdReady (cmdReady),
    .cmdAddr (cmdAddr), .cmdBroadcast (cmdBroadcast), .frameDropped (frameDropped),
    .respStart (respStart), .respAddr (respAddr), .respAddrValid (respAddrValid),
    .stationEnabled (stationEnabled), .txPos (txPos), .txNeg (txNeg), .txBit (txBit)
  );
  ssaf_peer   i_peer (
    .clk (clk), .rxByte (rxByte), .rxFirst (rxFirst), .rxLast (rxLast), .rxValid (rxValid), .rxReady (rxReady)
  );

  // compare and count
  task automatic check(input string nm, input logic [9:0] exp, input logic [9:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask : check
  // verdict and end of run
  task automatic stop_test();
    begin
      $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : stop_test
  // set both pairs, wait out the synchronisers
  task automatic lineCase(input logic dp, dn, rp, rn, eb, er);
    begin
      rxDataPos = dp;
      rxDataNeg = dn;
      requestPos = rp;
      requestNeg = rn;
      repeat (6) @(posedge clk);
      #1;
      check("rxBit", 10'(eb), 10'(rxBit));
      check("requestActive", 10'(er), 10'(requestActive));
    end
  endtask : lineCase

  // clock source
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // hang guard and output monitor
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
    if (!rst && frameDropped === 1'h1) nDrop++;
    if (!rst && cmdValid === 1'h1 && cmdReady) gotQ.push_back({cmdFirst, cmdLast, cmdByte});
    if (!rst && respAddrValid === 1'h1)
    begin
      nResp++;
      lastResp = respAddr;
    end
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    for (int i = 0; i < 12; i++)
    begin
      r = rows[i];
      stationRole = ssaf_role_e'(r.role);
      portSel = ssaf_port_e'(r.port);
      nd = nDrop;
      nq = gotQ.size();
      nr = nResp;
      i_peer.send(r.addr, 1'h1, 1'h1);
      i_peer.idle();
      // response requested on the edge right after the command is taken
      respStart = 1'h1;
      @(posedge clk);
      #1 respStart = 1'h0;
      repeat (4) @(posedge clk);
      #1;
      if (r.acc) expAddr = r.addr;
      check("stationEnabled", 10'(!(r.role && r.port)), 10'(stationEnabled));
      check("dropped", 10'(nd + !r.acc), 10'(nDrop));
      check("entries", 10'(nq + r.acc), 10'(gotQ.size()));
      if (r.acc) check("entry", {2'h3, r.addr}, gotQ[$]);
      if (r.acc) check("cmdBroadcast", 10'(r.bc), 10'(cmdBroadcast));
      check("cmdAddr", 10'(expAddr), 10'(cmdAddr));
      check("respCount", 10'(nr + 1), 10'(nResp));
      check("respAddr", 10'(expAddr), 10'(lastResp));
      $display("address row %0d done", i);
    end
    lineCase(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    lineCase(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    lineCase(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    lineCase(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    txBit = 1'h1;
    repeat (2) @(posedge clk);
    #1 check("txPair", 10'h2, 10'({txPos, txNeg}));
    txBit = 1'h0;
    repeat (2) @(posedge clk);
    #1 check("txPair", 10'h1, 10'({txPos, txNeg}));
    $display("line test done");
    // fill the buffer with a stalled reader, then drain it
    stationRole = SSAF_CPU;
    portSel = SSAF_PORT_FIO;
    cmdReady = 1'h0;
    nq = gotQ.size();
    for (int k = 0; k < 32; k++)
      i_peer.send((k == 0) ? 8'h13 : 8'(k), 1'(k == 0), 1'h0);
    i_peer.idle();
    repeat (3) @(posedge clk);
    #1 check("rxReady", 10'h0, 10'(rxReady));
    check("entries", 10'(nq), 10'(gotQ.size()));
    cmdReady = 1'h1;
    i_peer.send(8'h2a, 1'h0, 1'h1);
    i_peer.idle();
    repeat (40) @(posedge clk);
    #1 check("entries", 10'(nq + 33), 10'(gotQ.size()));
    for (int k = 0; k < 33; k++)
      check("entry", (k == 0) ? 10'h213 : (k == 32) ? 10'h12a : 10'(k), gotQ[nq + k]);
    $display("buffer test done");
    // second reset in mid run
    rst = 1'h1;
    repeat (2) @(posedge clk);
    #1 check("txPair", 10'h1, 10'({txPos, txNeg}));
    check("cmdAddr", 10'h0, 10'(cmdAddr));
    check("cmdValid", 10'h0, 10'(cmdValid));
    check("rxBit", 10'h0, 10'(rxBit));
    rst = 1'h0;
    // two edges after release the synchronisers have not yet passed the lines
    repeat (2) @(posedge clk);
    #1 check("rxBit", 10'h0, 10'(rxBit));
    check("requestActive", 10'h0, 10'(requestActive));
    check("respAddrValid", 10'h0, 10'(respAddrValid));
    check("txPair", 10'h1, 10'({txPos, txNeg}));
    repeat (3) @(posedge clk);
    #1 check("rxBit", 10'h1, 10'(rxBit));
    check("requestActive", 10'h1, 10'(requestActive));
    $display("reset test done");
    // foreign multi-byte frame swallowed whole, then an own frame passes
    stationRole = SSAF_FIELD_IO;
    portSel = SSAF_PORT_FIO;
    nd = nDrop;
    nq = gotQ.size();
    i_peer.send(8'h13, 1'h1, 1'h0);
    i_peer.send(8'h01, 1'h0, 1'h0);
    i_peer.send(8'h02, 1'h0, 1'h1);
    i_peer.send(8'h14, 1'h1, 1'h0);
    i_peer.send(8'h03, 1'h0, 1'h1);
    i_peer.idle();
    repeat (3) @(posedge clk);
    #1 check("dropped", 10'(nd + 1), 10'(nDrop));
    check("entries", 10'(nq + 2), 10'(gotQ.size()));
    check("entry", 10'h214, gotQ[nq]);
    check("entry", 10'h103, gotQ[nq + 1]);
    check("cmdAddr", 10'h14, 10'(cmdAddr));
    $display("drop frame test done");
    stop_test();
  end
endmodule : ssaf_filter_bench
`default_nettype wire
